// ==== src/fpc_pkg.sv ====
package fpc_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int FPC_PINS = 4;
   localparam int FPC_ADDR_W = 16;
   localparam int FPC_DATA_W = 16;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] FPC_ADDR_DATA = 16'hF228;
   localparam logic [15:0] FPC_ADDR_DIR = 16'hF229;
   localparam logic [15:0] FPC_ADDR_COND_LO = 16'hF22A;
   localparam logic [15:0] FPC_ADDR_COND_HI = 16'hF22B;
   localparam logic [15:0] FPC_ADDR_FUNC_LO = 16'hF22C;
   localparam logic [15:0] FPC_ADDR_FUNC_HI = 16'hF22D;

   // ----------------------------------------------------------------
   // field layout and values after reset
   // ----------------------------------------------------------------
   localparam int FPC_FIELD_LSB = 0;
   localparam int FPC_FIELD_MSB = 3;
   localparam logic [3:0] FPC_UPPER_ZERO = 4'h0;
   localparam logic [3:0] FPC_RST_NIBBLE = 4'h0;
   localparam logic [15:0] FPC_RST_RD = 16'h0000;
   localparam logic FPC_IDLE_UART_RX = 1'h1;
   localparam logic FPC_IDLE_SER_DATA = 1'h0;
   localparam logic FPC_IDLE_SER_CLK = 1'h0;

   // ----------------------------------------------------------------
   // pin settings
   // ----------------------------------------------------------------
   localparam logic FPC_DIR_OUT = 1'h0;
   localparam logic FPC_DIR_IN = 1'h1;

   typedef enum logic [1:0] {
      FPC_DRV_HIZ = 2'h0,
      FPC_DRV_PCH = 2'h1,
      FPC_DRV_NCH = 2'h2,
      FPC_DRV_CMOS = 2'h3
   } fpc_drv_t;

   typedef enum logic [1:0] {
      FPC_IN_HIZ = 2'h0,
      FPC_IN_PULL_DOWN = 2'h1,
      FPC_IN_PULL_UP = 2'h2,
      FPC_IN_HIZ_ALT = 2'h3
   } fpc_inp_t;

   typedef enum logic [1:0] {
      FPC_FN_GPIO = 2'h0,
      FPC_FN_ALT1 = 2'h1,
      FPC_FN_ALT2 = 2'h2,
      FPC_FN_ALT3 = 2'h3
   } fpc_fn_t;

endpackage

// ==== src/fpc_pad_drive.sv ====
`timescale 1ns/10ps

module fpc_pad_drive
(
   // pin setting
   input wire logic i_dir,
   input wire fpc_pkg::fpc_drv_t i_style,
   input wire logic i_level,
   input wire logic i_forbid,
   // pad controls
   output logic o_out,
   output logic o_oe,
   output logic o_pull_up,
   output logic o_pull_down
);
   import fpc_pkg::*;

   logic lvl;

   // ----------------------------------------------------------------
   // driver and pull selection
   // ----------------------------------------------------------------
   always_comb
   begin
      lvl = i_level & ~i_forbid;
      o_out = 1'h0;
      o_oe = 1'h0;
      o_pull_up = 1'h0;
      o_pull_down = 1'h0;
      if (i_dir == FPC_DIR_IN)
      begin
         case (fpc_inp_t'(i_style))
            FPC_IN_PULL_DOWN: o_pull_down = 1'h1;
            FPC_IN_PULL_UP: o_pull_up = 1'h1;
            default: o_pull_up = 1'h0;
         endcase
      end
      else
      begin
         case (i_style)
            FPC_DRV_PCH:
            begin
               o_out = 1'h1;
               o_oe = lvl;
            end
            FPC_DRV_NCH: o_oe = ~lvl;
            FPC_DRV_CMOS:
            begin
               o_out = lvl;
               o_oe = 1'h1;
            end
            default: o_oe = 1'h0;
         endcase
      end
   end

endmodule

// ==== src/fpc_port.sv ====
`timescale 1ns/10ps

module fpc_port
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // register port
   input wire logic [fpc_pkg::FPC_ADDR_W-1:0] i_addr,
   input wire logic [fpc_pkg::FPC_DATA_W-1:0] i_wr_data,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   input wire logic i_wide,
   output logic [fpc_pkg::FPC_DATA_W-1:0] o_rd_data,
   // port pins
   input wire logic [fpc_pkg::FPC_PINS-1:0] i_pin_in,
   output logic [fpc_pkg::FPC_PINS-1:0] o_pin_out,
   output logic [fpc_pkg::FPC_PINS-1:0] o_pin_oe,
   output logic [fpc_pkg::FPC_PINS-1:0] o_pin_pull_up,
   output logic [fpc_pkg::FPC_PINS-1:0] o_pin_pull_down,
   // peripheral sources
   input wire logic i_first_uart_transmit,
   input wire logic i_second_uart_transmit,
   input wire logic i_pwm_channel_output,
   input wire logic i_sync_serial_data_out,
   input wire logic i_sync_serial_clock_out,
   // peripheral sinks
   output logic o_second_uart_receive,
   output logic o_sync_serial_data_in,
   output logic o_sync_serial_clock_in
);
   import fpc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] data;
      logic [3:0] dir;
      logic [3:0] cond_lo;
      logic [3:0] cond_hi;
      logic [3:0] func_lo;
      logic [3:0] func_hi;
      logic [15:0] rd_data;
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic [3:0] pull_up;
      logic [3:0] pull_down;
      logic uart_rx;
      logic ser_din;
      logic ser_clk_in;
   } fpc_state_t;

   fpc_state_t r;
   fpc_state_t next_r;

   logic [3:0] pin_level;
   logic [3:0] pin_forbid;
   logic [3:0] pad_out;
   logic [3:0] pad_oe;
   logic [3:0] pad_pu;
   logic [3:0] pad_pd;
   logic [15:0] rd_value;
   logic [3:0] port_view;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic fpc_fn_t fn_code(input logic [3:0] hi, input logic [3:0] lo,
                                       input int idx);
      fn_code = fpc_fn_t'({hi[idx], lo[idx]});
   endfunction

   function automatic logic [7:0] rd_byte(input logic [3:0] field);
      rd_byte = {FPC_UPPER_ZERO, field};
   endfunction

   function automatic logic [3:0] wr_field(input logic [7:0] wbyte);
      wr_field = wbyte[FPC_FIELD_MSB:FPC_FIELD_LSB];
   endfunction

   // ----------------------------------------------------------------
   // function routing
   // ----------------------------------------------------------------
   always_comb
   begin
      pin_level = r.data;
      pin_forbid = 4'h0;
      case (fn_code(r.func_hi, r.func_lo, 3))
         FPC_FN_ALT1: pin_level[3] = i_second_uart_transmit;
         FPC_FN_ALT2: pin_level[3] = i_pwm_channel_output;
         FPC_FN_ALT3: pin_level[3] = i_first_uart_transmit;
         default: pin_level[3] = r.data[3];
      endcase
      case (fn_code(r.func_hi, r.func_lo, 2))
         FPC_FN_ALT2: pin_level[2] = i_sync_serial_data_out;
         FPC_FN_ALT3: pin_forbid[2] = 1'h1;
         default: pin_level[2] = r.data[2];
      endcase
      case (fn_code(r.func_hi, r.func_lo, 1))
         FPC_FN_ALT2: pin_level[1] = i_sync_serial_clock_out;
         FPC_FN_ALT1: pin_forbid[1] = 1'h1;
         FPC_FN_ALT3: pin_forbid[1] = 1'h1;
         default: pin_level[1] = r.data[1];
      endcase
      case (fn_code(r.func_hi, r.func_lo, 0))
         FPC_FN_ALT1: pin_forbid[0] = 1'h1;
         FPC_FN_ALT3: pin_forbid[0] = 1'h1;
         default: pin_level[0] = r.data[0];
      endcase
   end

   // ----------------------------------------------------------------
   // pad drivers
   // ----------------------------------------------------------------
   for (genvar g = 0; g < FPC_PINS; g++)
   begin : g_pad
      fpc_pad_drive u_pad
      (
         .i_dir(r.dir[g]),
         .i_style(fpc_drv_t'({r.cond_hi[g], r.cond_lo[g]})),
         .i_level(pin_level[g]),
         .i_forbid(pin_forbid[g]),
         .o_out(pad_out[g]),
         .o_oe(pad_oe[g]),
         .o_pull_up(pad_pu[g]),
         .o_pull_down(pad_pd[g])
      );
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   always_comb
   begin
      port_view = (r.dir & i_pin_in) | (~r.dir & r.data);
      rd_value = FPC_RST_RD;
      case (i_addr)
         FPC_ADDR_DATA: rd_value[7:0] = rd_byte(port_view);
         FPC_ADDR_DIR: rd_value[7:0] = rd_byte(r.dir);
         FPC_ADDR_COND_LO:
         begin
            rd_value[7:0] = rd_byte(r.cond_lo);
            if (i_wide)
            begin
               rd_value[15:8] = rd_byte(r.cond_hi);
            end
         end
         FPC_ADDR_COND_HI: rd_value[7:0] = rd_byte(r.cond_hi);
         FPC_ADDR_FUNC_LO:
         begin
            rd_value[7:0] = rd_byte(r.func_lo);
            if (i_wide)
            begin
               rd_value[15:8] = rd_byte(r.func_hi);
            end
         end
         FPC_ADDR_FUNC_HI: rd_value[7:0] = rd_byte(r.func_hi);
         default: rd_value = FPC_RST_RD;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.rd_data = i_rd_stb ? rd_value : FPC_RST_RD;
      if (i_wr_stb)
      begin
         case (i_addr)
            FPC_ADDR_DATA: next_r.data = wr_field(i_wr_data[7:0]);
            FPC_ADDR_DIR: next_r.dir = wr_field(i_wr_data[7:0]);
            FPC_ADDR_COND_LO:
            begin
               next_r.cond_lo = wr_field(i_wr_data[7:0]);
               if (i_wide)
               begin
                  next_r.cond_hi = wr_field(i_wr_data[15:8]);
               end
            end
            FPC_ADDR_COND_HI: next_r.cond_hi = wr_field(i_wr_data[7:0]);
            FPC_ADDR_FUNC_LO:
            begin
               next_r.func_lo = wr_field(i_wr_data[7:0]);
               if (i_wide)
               begin
                  next_r.func_hi = wr_field(i_wr_data[15:8]);
               end
            end
            FPC_ADDR_FUNC_HI: next_r.func_hi = wr_field(i_wr_data[7:0]);
            default: next_r.data = r.data;
         endcase
      end
      next_r.pin_out = pad_out;
      next_r.pin_oe = pad_oe;
      next_r.pull_up = pad_pu;
      next_r.pull_down = pad_pd;
      next_r.uart_rx = FPC_IDLE_UART_RX;
      next_r.ser_din = FPC_IDLE_SER_DATA;
      next_r.ser_clk_in = FPC_IDLE_SER_CLK;
      if (fn_code(r.func_hi, r.func_lo, 2) == FPC_FN_ALT1)
      begin
         next_r.uart_rx = i_pin_in[2];
      end
      if (fn_code(r.func_hi, r.func_lo, 0) == FPC_FN_ALT2)
      begin
         next_r.ser_din = i_pin_in[0];
      end
      if (fn_code(r.func_hi, r.func_lo, 1) == FPC_FN_ALT2)
      begin
         next_r.ser_clk_in = i_pin_in[1];
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         r <= '{
            data: FPC_RST_NIBBLE,
            dir: FPC_RST_NIBBLE,
            cond_lo: FPC_RST_NIBBLE,
            cond_hi: FPC_RST_NIBBLE,
            func_lo: FPC_RST_NIBBLE,
            func_hi: FPC_RST_NIBBLE,
            rd_data: FPC_RST_RD,
            pin_out: FPC_RST_NIBBLE,
            pin_oe: FPC_RST_NIBBLE,
            pull_up: FPC_RST_NIBBLE,
            pull_down: FPC_RST_NIBBLE,
            uart_rx: FPC_IDLE_UART_RX,
            ser_din: FPC_IDLE_SER_DATA,
            ser_clk_in: FPC_IDLE_SER_CLK
         };
      end
      else if (i_clk_en)
      begin
         r <= next_r;
      end
   end

   assign o_rd_data = r.rd_data;
   assign o_pin_out = r.pin_out;
   assign o_pin_oe = r.pin_oe;
   assign o_pin_pull_up = r.pull_up;
   assign o_pin_pull_down = r.pull_down;
   assign o_second_uart_receive = r.uart_rx;
   assign o_sync_serial_data_in = r.ser_din;
   assign o_sync_serial_clock_in = r.ser_clk_in;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_reset_clear : assert property (disable iff (1'b0) !i_rst_n |=>
      (r.dir == 4'h0 && r.cond_lo == 4'h0 && r.cond_hi == 4'h0 && o_pin_oe == 4'h0))
      else $error("reset did not release all pins");

   for (genvar k = 0; k < FPC_PINS; k++)
   begin : g_chk
      a_hiz_release : assert property (i_clk_en && !r.dir[k] &&
         {r.cond_hi[k], r.cond_lo[k]} == 2'h0 |=> !o_pin_oe[k])
         else $error("released style drove the pin");
      a_nch_sink : assert property (i_clk_en && !r.dir[k] && !pin_level[k] &&
         {r.cond_hi[k], r.cond_lo[k]} == 2'h2 |=> o_pin_oe[k] && !o_pin_out[k])
         else $error("low-only style failed to sink");
      a_gpio_cmos : assert property (i_clk_en && !r.dir[k] &&
         {r.cond_hi[k], r.cond_lo[k]} == 2'h3 && {r.func_hi[k], r.func_lo[k]} == 2'h0
         |=> o_pin_oe[k] && o_pin_out[k] == $past(r.data[k]))
         else $error("push-pull pin does not follow data");
      a_input_pulls : assert property (i_clk_en && r.dir[k] |=> !o_pin_oe[k] &&
         o_pin_pull_up[k] == ($past({r.cond_hi[k], r.cond_lo[k]}) == 2'h2) &&
         o_pin_pull_down[k] == ($past({r.cond_hi[k], r.cond_lo[k]}) == 2'h1))
         else $error("input condition wrong");
      a_read_view : assert property (i_clk_en && i_rd_stb && i_addr == FPC_ADDR_DATA
         |=> o_rd_data[k] == ($past(r.dir[k]) ? $past(i_pin_in[k]) : $past(r.data[k])))
         else $error("data read shows wrong source");
      a_pch_source : assert property (i_clk_en && !r.dir[k] && pin_level[k] &&
         !pin_forbid[k] && {r.cond_hi[k], r.cond_lo[k]} == 2'h1 |=> o_pin_oe[k] && o_pin_out[k])
         else $error("high-only style failed to source");
   end

   a_pin3_uart : assert property (i_clk_en && !r.dir[3] && r.cond_hi[3] && r.cond_lo[3] &&
      r.func_hi[3] && r.func_lo[3] |=> o_pin_out[3] == $past(i_first_uart_transmit))
      else $error("pin 3 not routed to first uart");
   a_pin2_sdo : assert property (i_clk_en && !r.dir[2] && r.cond_hi[2] && r.cond_lo[2] &&
      r.func_hi[2] && !r.func_lo[2] |=> o_pin_out[2] == $past(i_sync_serial_data_out))
      else $error("pin 2 not routed to serial data");
   a_pin1_clock : assert property (i_clk_en && r.func_hi[1] && !r.func_lo[1]
      |=> o_sync_serial_clock_in == $past(i_pin_in[1]))
      else $error("pin 1 clock not forwarded");
   a_pin0_sdi : assert property (i_clk_en && r.func_hi[0] && !r.func_lo[0]
      |=> o_sync_serial_data_in == $past(i_pin_in[0]))
      else $error("pin 0 data not forwarded");
   a_forbid_low : assert property (i_clk_en && !r.dir[0] && r.cond_hi[0] &&
      r.func_lo[0] |=> o_pin_oe[0] && !o_pin_out[0])
      else $error("prohibited code not held low");

   sequence s_func_write;
      i_clk_en && i_wr_stb && !i_wide && i_addr == FPC_ADDR_FUNC_LO;
   endsequence
   sequence s_func_read;
      i_clk_en && i_rd_stb && !i_wide && i_addr == FPC_ADDR_FUNC_LO;
   endsequence
   a_func_readback : assert property (s_func_write ##1 !i_wr_stb ##1 s_func_read |=>
      o_rd_data == {8'h00, FPC_UPPER_ZERO, $past(i_wr_data[3:0], 3)})
      else $error("function register readback wrong");

   a_read_idle : assert property (i_clk_en && !i_rd_stb |=> o_rd_data == FPC_RST_RD)
      else $error("read data stood outside its cycle");
   a_uart_idle : assert property (i_clk_en && !(r.func_lo[2] && !r.func_hi[2])
      |=> o_second_uart_receive)
      else $error("uart receive not idle");
   a_clock_idle : assert property (i_clk_en && !(r.func_hi[1] && !r.func_lo[1])
      |=> !o_sync_serial_clock_in)
      else $error("serial clock not idle");

endmodule

// ==== dv/fpc_board_model.sv ====
`timescale 1ns/10ps

module fpc_board_model
(
   // clock
   input wire logic i_sys_clk,
   // pad controls from the port
   input wire logic [3:0] i_out,
   input wire logic [3:0] i_oe,
   input wire logic [3:0] i_pull_up,
   input wire logic [3:0] i_pull_down,
   // board drivers
   input wire logic [3:0] i_ext,
   input wire logic [3:0] i_ext_en,
   // resolved pin levels
   output logic [3:0] o_pin
);
   logic [3:0] flt = 4'h5;

   // ----------------------------------------------------------------
   // pin resolution
   // ----------------------------------------------------------------
   // a pin nobody drives or pulls wanders every cycle
   always @(posedge i_sys_clk)
      flt <= ~flt;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (i_oe[i])
            o_pin[i] = i_out[i];
         else if (i_ext_en[i])
            o_pin[i] = i_ext[i];
         else if (i_pull_up[i])
            o_pin[i] = 1'h1;
         else if (i_pull_down[i])
            o_pin[i] = 1'h0;
         else
            o_pin[i] = flt[i];
      end
   end
endmodule

// ==== dv/fpc_port_tb.sv ====
`timescale 1ns/10ps

module fpc_port_tb;
   import fpc_pkg::*;

   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic clk_en = 1'h1;
   logic [15:0] addr = 16'h0;
   logic [15:0] wdat = 16'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic wide = 1'h0;
   logic [15:0] rdat;
   logic [3:0] pin;
   logic [3:0] pout;
   logic [3:0] poe;
   logic [3:0] ppu;
   logic [3:0] ppd;
   logic [3:0] ext = 4'h0;
   logic [3:0] ext_en = 4'h0;
   // peripheral levels: tx1, tx2, pwm, sdo, sck
   logic [4:0] per = 5'h0;
   logic urx;
   logic sdi;
   logic sck;
   logic [31:0] seed = 32'hA66E;
   logic [15:0] sv;
   int m[6];
   int miscompares = 0;
   int n_checks = 0;

   always #20 clk = ~clk;

   fpc_port dut
   (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
      .i_addr(addr), .i_wr_data(wdat), .i_wr_stb(wr), .i_rd_stb(rd),
      .i_wide(wide), .o_rd_data(rdat),
      .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
      .o_pin_pull_up(ppu), .o_pin_pull_down(ppd),
      .i_first_uart_transmit(per[4]), .i_second_uart_transmit(per[3]),
      .i_pwm_channel_output(per[2]), .i_sync_serial_data_out(per[1]),
      .i_sync_serial_clock_out(per[0]),
      .o_second_uart_receive(urx), .o_sync_serial_data_in(sdi),
      .o_sync_serial_clock_in(sck)
   );

   fpc_board_model board
   (
      .i_sys_clk(clk), .i_out(pout), .i_oe(poe), .i_pull_up(ppu),
      .i_pull_down(ppd), .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got,
      input logic [15:0] msk);
      n_checks++;
      if ((got & msk) !== (exp & msk))
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp & msk, got & msk);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d, input logic w);
      int k;
      k = int'(a) - int'(FPC_ADDR_DATA);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wide <= w;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      if (k >= 0 && k < 6)
         m[k] = d[3:0];
      if (w && (k == 2 || k == 4))
         m[k + 1] = d[11:8];
   endtask

   task automatic rd_reg(input logic [15:0] a, input logic w, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wide <= w;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdat;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      for (int k = 0; k < 6; k++)
         m[k] = 0;
   endtask

   // expected pad state: {known, level, oe, out, pull_up, pull_down}
   function automatic logic [5:0] expect_pin(input int i);
      logic d;
      logic lv;
      logic oe;
      logic [1:0] st;
      logic [1:0] fn;
      d = m[1][i];
      st = {m[3][i], m[2][i]};
      fn = {m[5][i], m[4][i]};
      lv = m[0][i];
      case (i)
         3: lv = fn == 2'h0 ? lv : fn == 2'h1 ? per[3] : fn == 2'h2 ? per[2] : per[4];
         2: lv = fn == 2'h3 ? 1'h0 : fn == 2'h2 ? per[1] : lv;
         1: lv = fn == 2'h2 ? per[0] : fn == 2'h0 ? lv : 1'h0;
         default: lv = fn[0] ? 1'h0 : lv;
      endcase
      oe = !d && (st == 2'h3 || (st == 2'h1 && lv) || (st == 2'h2 && !lv));
      lv = st == 2'h3 ? lv : st == 2'h1;
      return {oe || ext_en[i] || (d && st[1] != st[0]),
              oe ? lv : ext_en[i] ? ext[i] : st == 2'h2,
              oe, lv, d && st == 2'h2, d && st == 2'h1};
   endfunction

   task automatic check_all();
      logic [5:0] e[4];
      logic [15:0] rv;
      logic [15:0] ex;
      logic [15:0] msk;
      logic u;
      logic s0;
      logic s1;
      repeat (3) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++)
      begin
         e[i] = expect_pin(i);
         chk("pin enable", e[i][3], poe[i], 16'h1);
         chk("pin level", e[i][2], pout[i], {15'h0, e[i][3]});
         chk("pin pulls", e[i][1:0], {ppu[i], ppd[i]}, 16'h3);
      end
      u = m[4][2] && !m[5][2];
      s0 = m[5][0] && !m[4][0];
      s1 = m[5][1] && !m[4][1];
      chk("uart receive", u ? e[2][4] : 1'h1, urx, {15'h0, !u || e[2][5]});
      chk("serial data in", s0 && e[0][4], sdi, {15'h0, !s0 || e[0][5]});
      chk("serial clock in", s1 && e[1][4], sck, {15'h0, !s1 || e[1][5]});
      for (int k = 0; k < 6; k++)
      begin
         rd_reg(FPC_ADDR_DATA + 16'(k), 1'h0, rv);
         ex = 16'(m[k]);
         msk = 16'hFFFF;
         for (int i = 0; i < 4; i++)
            if (k == 0 && m[1][i])
            begin
               ex[i] = e[i][4];
               msk[i] = e[i][5];
            end
         chk("register read", ex, rv, msk);
      end
      rd_reg(FPC_ADDR_COND_LO, 1'h1, rv);
      chk("word read cond", 16'(m[2] + m[3] * 256), rv, 16'hFFFF);
      rd_reg(FPC_ADDR_FUNC_LO, 1'h1, rv);
      chk("word read func", 16'(m[4] + m[5] * 256), rv, 16'hFFFF);
      rd_reg(16'hF22E, 1'h0, rv);
      chk("unmapped read", 16'h0, rv, 16'hFFFF);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      do_reset();
      check_all();
      for (int n = 0; n < 60; n++)
      begin
         r = rnd();
         @(posedge clk);
         ext <= r[3:0];
         ext_en <= r[7:4] | r[11:8];
         per <= r[16:12];
         for (int k = 0; k < 6; k++)
            wr_reg(FPC_ADDR_DATA + 16'(k), 16'(rnd()), 1'h0);
         if (r[17])
            wr_reg(r[18] ? FPC_ADDR_FUNC_LO : FPC_ADDR_COND_LO, 16'(rnd()), 1'h1);
         wr_reg(16'hF22E, 16'(rnd()), 1'h0);
         wr_reg(FPC_ADDR_FUNC_LO, 16'(rnd()), 1'h0);
         rd_reg(FPC_ADDR_FUNC_LO, 1'h0, sv);
         chk("function readback", 16'(m[4]), sv, 16'hFFFF);
         check_all();
      end
      // a write while the clock enable is low is lost
      @(posedge clk);
      clk_en <= 1'h0;
      sv = 16'(m[0]);
      wr_reg(FPC_ADDR_DATA, ~sv, 1'h0);
      m[0] = int'(sv);
      clk_en <= 1'h1;
      check_all();
      do_reset();
      check_all();
      end_sim();
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      miscompares++;
      end_sim();
   end
endmodule
